// file: logic/lec_regs.sv
// Lane error count hold configuration for lanes 5 to 7, paged by link,
// with the error counters they steer, terminal status and an interrupt.
// Assumes an APB master on pclk and error events from the lane decoder on pclk.
`default_nettype none
module lec_regs
    import lec_pkg::*;
(
    input  wire logic                                      pclk,
    input  wire logic                                      presetn,
    input  wire logic                                      ce,
    input  wire logic [lec_pkg::ADDR_W-1:0]                paddr,
    input  wire logic                                      psel,
    input  wire logic                                      penable,
    input  wire logic                                      pwrite,
    input  wire logic [lec_pkg::DATA_W-1:0]                pwdata,
    output logic      [lec_pkg::DATA_W-1:0]                prdata,
    output logic                                           pready,
    output logic                                           pslverr,
    input  wire lec_pkg::lec_err_s [lec_pkg::IRQ_W-1:0]    err_evt,
    output logic                                           decoder_soft_reset,
    output logic                                           irq
);
    import lec_pkg::*;

    // Register state
    logic [NUM_LINKS-1:0][NUM_LANES-1:0][SAT_W-1:0] sat_reg;
    logic                                           page_reg;
    logic                                           soft_rst_reg;
    logic [IRQ_W-1:0]                               irq_stat_reg;
    logic [IRQ_W-1:0]                               irq_mask_reg;
    logic [DATA_W-1:0]                              prdata_reg;
    logic                                           pready_reg;
    logic                                           pslverr_reg;
    logic                                           irq_reg;

    // Counter state
    logic [NUM_LINKS-1:0][NUM_LANES-1:0][SAT_W-1:0] term_vec;
    logic [NUM_LINKS-1:0][NUM_LANES-1:0][SAT_W-1:0] hit_vec;
    logic [NUM_LINKS-1:0][NUM_LANES-1:0][SAT_W-1:0] clr_vec;
    lec_cnt_s [NUM_LINKS-1:0][NUM_LANES-1:0]        cnt_vec;
    logic [IRQ_W-1:0]                               hit_lane;

    // Bus decode
    logic [IDX_W-1:0]  idx;
    logic              aligned;
    logic              setup;
    logic              wr_done;
    logic              is_sat;
    logic              is_cnt;
    logic              mapped;
    logic [1:0]        lane_sel;
    logic [DATA_W-1:0] rd_data;
    logic [IRQ_W-1:0]  irq_stat_next;

    assign idx      = paddr[ADDR_W-1:2];
    assign aligned  = (paddr[1:0] == 2'h0);
    assign setup    = psel & ~penable;
    // A write lands only at the edge where the access phase sees pready
    assign wr_done  = ce & psel & penable & pwrite & pready_reg;
    assign is_sat   = (idx >= IDX_SAT5) && (idx <= IDX_SAT7);
    assign is_cnt   = (idx >= IDX_CNT5) && (idx <= IDX_CNT5 + 12'h002);
    assign lane_sel = is_sat ? idx[1:0] - IDX_SAT5[1:0] : idx[1:0] - IDX_CNT5[1:0];
    assign mapped   = aligned & (is_sat | is_cnt
                                 | (idx == IDX_PAGE) | (idx == IDX_SOFT_RST)
                                 | (idx == IDX_TERM) | (idx == IDX_CLR)
                                 | (idx == IDX_IRQ_STAT) | (idx == IDX_IRQ_MASK));

    // Read selection; saturate, terminal and counter views follow the page field, the interrupt status and mask do not
    assign rd_data =
        !mapped                ? '0 :
        (idx == IDX_PAGE)      ? DATA_W'(page_reg) << PAGE_BIT :
        (idx == IDX_SOFT_RST)  ? DATA_W'(soft_rst_reg) << SOFT_RST_BIT :
        is_sat                 ? DATA_W'(sat_reg[page_reg][lane_sel]) :
        (idx == IDX_TERM)      ? DATA_W'(term_vec[page_reg]) :
        is_cnt                 ? DATA_W'(cnt_vec[page_reg][lane_sel]) :
        (idx == IDX_IRQ_STAT)  ? DATA_W'(irq_stat_reg) :
        (idx == IDX_IRQ_MASK)  ? DATA_W'(irq_mask_reg) :
                                 '0;

    // Sticky lane events: hardware set beats software clear
    assign irq_stat_next = hit_lane
        | (irq_stat_reg & ~(((idx == IDX_IRQ_STAT) && wr_done && aligned)
                            ? pwdata[IRQ_W-1:0] : '0));

    // Answer is prepared in the setup cycle, so the access phase takes one cycle with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~mapped;
            prdata_reg  <= (setup && !pwrite) ? rd_data : '0;
        end
    end

    // Page, soft reset, mask and interrupt state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_reg     <= PAGE_RST;
            soft_rst_reg <= SOFT_RST_RST;
            irq_mask_reg <= '0;
            irq_stat_reg <= '0;
            irq_reg      <= 1'b0;
        end else if (ce) begin
            if (wr_done && aligned && idx == IDX_PAGE)
                page_reg <= pwdata[PAGE_BIT];
            if (wr_done && aligned && idx == IDX_SOFT_RST)
                soft_rst_reg <= pwdata[SOFT_RST_BIT];
            if (wr_done && aligned && idx == IDX_IRQ_MASK)
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            irq_stat_reg <= irq_stat_next;
            irq_reg      <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // Saturate-enable fields; writes outside decoder soft reset are dropped,
    // which shields running counters from a mid-stream change of mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sat_reg <= {(NUM_LINKS * NUM_LANES){SAT_RST}};
        end else if (ce && wr_done && aligned && is_sat && soft_rst_reg) begin
            sat_reg[page_reg][lane_sel] <= pwdata[SAT_W-1:0];
        end
    end

    // One counter per link, lane and error kind
    genvar k, l, t;
    generate
        for (k = 0; k < NUM_LINKS; k++) begin : g_link
            for (l = 0; l < NUM_LANES; l++) begin : g_lane
                logic [SAT_W-1:0][CNT_W-1:0] cnt_w;
                for (t = 0; t < SAT_W; t++) begin : g_kind
                    // Clear hits only the paged link, one bit per counter
                    assign clr_vec[k][l][t] = wr_done && aligned && (idx == IDX_CLR)
                        && (page_reg == 1'(k)) && pwdata[l * SAT_W + t];
                    lec_err_counter #(.CNT_W(CNT_W)) u_cnt (
                        .pclk         (pclk),
                        .presetn      (presetn),
                        .ce           (ce),
                        .evt          (err_evt[k * NUM_LANES + l][t]),
                        .hold         (sat_reg[k][l][t]),
                        .clr          (clr_vec[k][l][t]),
                        .count        (cnt_w[t]),
                        .term_reached (term_vec[k][l][t]),
                        .term_hit     (hit_vec[k][l][t])
                    );
                end
                assign cnt_vec[k][l] = {cnt_w[CTRL_BIT], cnt_w[SYM_BIT], cnt_w[DISP_BIT]};
                assign hit_lane[k * NUM_LANES + l] = |hit_vec[k][l];
            end
        end
    endgenerate

    // Outputs straight from flip-flops
    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign decoder_soft_reset = soft_rst_reg;
    assign irq                = irq_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_page_write_lane5: assert property (
        wr_done && aligned && idx == IDX_SAT5 && soft_rst_reg
        |=> sat_reg[$past(page_reg)][0] == $past(pwdata[SAT_W-1:0])
    ) else $error("lane 5 setting not stored in the paged link");

    a_cfg_frozen_run: assert property (
        !soft_rst_reg |=> $stable(sat_reg)
    ) else $error("setting changed outside decoder soft reset");

    a_ctrl_bit_wrap: assert property (
        ce && !sat_reg[0][0][CTRL_BIT] && err_evt[0].ctrl_err && !clr_vec[0][0][CTRL_BIT]
        && cnt_vec[0][0].ctrl_err == CNT_TERM |=> cnt_vec[0][0].ctrl_err == '0
    ) else $error("top field bit does not steer the control character counter");

    a_disp_bit_hold: assert property (
        ce && sat_reg[0][0][DISP_BIT] && !clr_vec[0][0][DISP_BIT]
        && cnt_vec[0][0].disp_err == CNT_TERM |=> cnt_vec[0][0].disp_err == CNT_TERM
    ) else $error("low field bit does not hold the disparity counter");

    a_term_status_irq: assert property (
        ce && hit_vec[0][0][CTRL_BIT]
        |=> irq_stat_reg[0] && term_vec[0][0][CTRL_BIT] && (irq_reg || !$past(irq_mask_reg[0]))
    ) else $error("terminal event did not reach status and interrupt");

    a_apb_one_wait: assert property (
        ce && setup |=> pready_reg ##1 !pready_reg || $past(setup)
    ) else $error("access phase not answered in one cycle");

    a_unmapped_err: assert property (
        ce && setup && !mapped |=> pslverr_reg && prdata_reg == '0
    ) else $error("unmapped access not flagged");

    a_irq_masked_low: assert property (
        ce && irq_mask_reg == '0 ##1 ce && irq_mask_reg == '0 |-> !irq_reg
    ) else $error("masked interrupt reached the output");
endmodule
`default_nettype wire

// file: logic/lec_pkg.sv
// Shared constants and carrier types for the lane error count hold block.
// Assumes a single register clock domain and an APB master with 32-bit data.
`default_nettype none
package lec_pkg;
    // Geometry
    localparam int ADDR_W    = 14;
    localparam int DATA_W    = 32;
    localparam int NUM_LINKS = 2;
    localparam int NUM_LANES = 3;
    localparam int CNT_W     = 8;
    localparam int SAT_W     = 3;
    localparam int IDX_W     = 12;
    localparam int IRQ_W     = NUM_LINKS * NUM_LANES;
    localparam int PAGE_CNT  = NUM_LANES * SAT_W;
    // Register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PAGE     = 12'h300;
    localparam logic [IDX_W-1:0] IDX_SOFT_RST = 12'h475;
    localparam logic [IDX_W-1:0] IDX_SAT5     = 12'h48D;
    localparam logic [IDX_W-1:0] IDX_SAT6     = 12'h48E;
    localparam logic [IDX_W-1:0] IDX_SAT7     = 12'h48F;
    localparam logic [IDX_W-1:0] IDX_TERM     = 12'h4A0;
    localparam logic [IDX_W-1:0] IDX_CLR      = 12'h4A1;
    localparam logic [IDX_W-1:0] IDX_CNT5     = 12'h4A2;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'h4A8;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h4A9;
    // Field positions
    localparam int PAGE_BIT     = 0;
    localparam int SOFT_RST_BIT = 3;
    localparam int CTRL_BIT     = 2;
    localparam int SYM_BIT      = 1;
    localparam int DISP_BIT     = 0;
    // Reset values and the counter terminal value
    localparam logic [SAT_W-1:0] SAT_RST      = 3'h7;
    localparam logic             SOFT_RST_RST = 1'b0;
    localparam logic             PAGE_RST     = 1'b0;
    localparam logic [CNT_W-1:0] CNT_TERM     = 8'hFF;
    // One lane's error events, top bit first
    typedef struct packed {
        logic ctrl_err;
        logic sym_err;
        logic disp_err;
    } lec_err_s;
    // Counter group of one lane as read back
    typedef struct packed {
        logic [CNT_W-1:0] ctrl_err;
        logic [CNT_W-1:0] sym_err;
        logic [CNT_W-1:0] disp_err;
    } lec_cnt_s;
endpackage
`default_nettype wire

// file: logic/lec_err_counter.sv
// One eight-bit error counter with terminal-count hold or wrap.
// Assumes events come from logic on pclk; clear comes from the register file.
`default_nettype none
module lec_err_counter #(
    parameter int CNT_W = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic             evt,
    input  wire logic             hold,
    input  wire logic             clr,
    output logic [CNT_W-1:0]      count,
    output logic                  term_reached,
    output logic                  term_hit
);
    localparam logic [CNT_W-1:0] TERM = {CNT_W{1'b1}};

    logic [CNT_W-1:0] count_next;
    logic             at_term;

    // Hold at the top when enabled, else roll over
    assign at_term    = (count == TERM);
    assign term_hit   = evt & (count == TERM - 1'b1);
    assign count_next = clr ? '0 :
                        !evt ? count :
                        at_term ? (hold ? count : '0) :
                        count + 1'b1;

    // Flag set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count        <= '0;
            term_reached <= 1'b0;
        end else if (ce) begin
            count        <= count_next;
            term_reached <= term_hit | (term_reached & ~clr);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_hold_at_term: assert property (
        ce && at_term && hold && !clr |=> count == TERM
    ) else $error("held counter left terminal value");

    a_wrap_past_term: assert property (
        ce && evt && at_term && !hold && !clr |=> count == '0
    ) else $error("free counter did not wrap");

    a_count_step: assert property (
        ce && evt && !at_term && !clr |=> count == $past(count) + 1'b1
    ) else $error("counter did not advance by one");

    a_term_flag: assert property (
        ce && term_hit |=> term_reached
    ) else $error("terminal flag not raised");
endmodule
`default_nettype wire

// file: verif/lec_err_src.sv
// Error event source standing in for the lane decoder behind the serial lanes.
// Assumes the bench holds elem and kinds steady while busy is high.
`default_nettype none
module lec_err_src
    import lec_pkg::*;
(
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  start,
    input  wire logic [2:0]                            elem,
    input  wire lec_pkg::lec_err_s                     kinds,
    input  wire logic [8:0]                            n,
    output var  lec_pkg::lec_err_s [lec_pkg::IRQ_W-1:0] err_evt,
    output logic                                       busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] left_reg;
    // Burst length loads on start, then counts down one event a cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) left_reg <= 9'h000;
        else if (start) left_reg <= n;
        else if (busy) left_reg <= left_reg - 9'h001;
    end
    assign busy = (left_reg != 9'h000);
    // Single-cycle pulses, quiet between bursts so no event is counted twice
    always_comb begin
        err_evt = '0;
        if (busy) err_evt[elem] = kinds;
    end
endmodule
`default_nettype wire

// file: verif/lec_regs_tb.sv
// Self-checking bench for the lane error count hold register block.
// Assumes one pclk domain; ce drops only in the freeze scenario.
`default_nettype none
module lec_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lec_pkg::*;
    logic                    pclk, presetn, psel, penable, pwrite, start, ce;
    logic [ADDR_W-1:0]       paddr;
    logic [DATA_W-1:0]       pwdata, prdata, q;
    logic                    pready, pslverr, decoder_soft_reset, irq, busy, e;
    logic [2:0]              elem;
    lec_err_s                kinds;
    lec_err_s [IRQ_W-1:0]    err_evt;
    int                      n_mismatch, checks, cyc;
    lec_regs lec_regs_i (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .err_evt(err_evt),
        .decoder_soft_reset(decoder_soft_reset), .irq(irq));
    lec_err_src lec_err_src_i (.pclk(pclk), .presetn(presetn), .start(start), .elem(elem),
        .kinds(kinds), .n(9'h100), .err_evt(err_evt), .busy(busy));
    task automatic wrap_up();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            $display("BAD %s expected %h seen %h", nm, x, g);
            n_mismatch++;
        end
    endtask
    // One APB transfer; waits for pready instead of assuming the latency
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 50) n_mismatch++;
    endtask
    task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask
    task automatic rd(input logic [IDX_W-1:0] i, input string nm, input logic [31:0] x);
        apb(1'b0, {i, 2'b00}, 32'h0);
        chk(nm, x, q);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask
    // Reset values of the three link 0 saturate fields, the page and the soft reset bit
    task automatic t_reset();
        rd(IDX_SAT5, "sat5", 32'h7);
        rd(IDX_SAT6, "sat6", 32'h7);
        rd(IDX_SAT7, "sat7", 32'h7);
        rd(IDX_PAGE, "page", 32'h0);
        chk("soft_rst", 32'h0, {31'h0, decoder_soft_reset});
    endtask
    // Settings change under soft reset only, and only on the paged link
    task automatic t_config();
        wr(IDX_SAT5, 32'h0);
        rd(IDX_SAT5, "sat5 gated", 32'h7);
        wr(IDX_SOFT_RST, 32'h8);
        // The write lands at the edge the transfer ends on; look one edge later
        @(posedge pclk);
        chk("soft_rst on", 32'h1, {31'h0, decoder_soft_reset});
        wr(IDX_SAT5, 32'h1); // Lowest bit only: bad disparity holds, the others wrap
        rd(IDX_SAT5, "sat5 set", 32'h1);
        wr(IDX_PAGE, 32'h1);
        rd(IDX_SAT5, "sat5 link1", 32'h7);
        wr(IDX_PAGE, 32'h0);
        wr(IDX_SOFT_RST, 32'h0);
    endtask
    // One burst of 256 pulses from the source; a source that never drains is a mismatch
    task automatic burst(input logic [2:0] el, input lec_err_s kd);
        int k;
        k = 0;
        elem <= el;
        kinds <= kd;
        @(posedge pclk);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1 && k < 400) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 400) n_mismatch++;
    endtask
    // 256 events: the wrapping counter returns to 0, the held one stays at 0xFF
    task automatic t_count();
        wr(IDX_IRQ_MASK, 32'h0);
        burst(3'h0, '{ctrl_err: 1'b1, sym_err: 1'b0, disp_err: 1'b1});
        rd(IDX_CNT5, "cnt5", 32'h0000_00FF);
        rd(IDX_TERM, "term", 32'h5);
        rd(IDX_IRQ_STAT, "irq_stat", 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(IDX_PAGE, 32'h1);
        rd(IDX_CNT5, "cnt5 link1", 32'h0);
        wr(IDX_PAGE, 32'h0);
    endtask
    // Interrupt unmasked, then counter and sticky status cleared
    task automatic t_irq();
        wr(IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(IDX_CLR, 32'h1FF);
        rd(IDX_CNT5, "cnt5 clr", 32'h0);
        rd(IDX_TERM, "term clr", 32'h0);
        wr(IDX_IRQ_STAT, 32'h3F);
        repeat (2) @(posedge pclk);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask
    // Clock enable low freezes every counter: a whole burst leaves no trace
    task automatic t_freeze();
        ce <= 1'b0;
        burst(3'h1, '{ctrl_err: 1'b1, sym_err: 1'b1, disp_err: 1'b1});
        ce <= 1'b1;
        rd(IDX_CNT5 + 12'h001, "cnt6 frozen", 32'h0);
        rd(IDX_TERM, "term frozen", 32'h0);
    endtask
    // Unmapped and misaligned addresses answer with an error and zero data
    task automatic t_bad_addr();
        apb(1'b0, 14'h0010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        // Soft reset on, so only the misalignment can keep the field unchanged
        wr(IDX_SOFT_RST, 32'h8);
        apb(1'b1, 14'h1235, 32'h0);
        chk("misaligned err", 32'h1, {31'h0, e});
        rd(IDX_SAT5, "sat5 kept", 32'h1);
        rd(IDX_SAT6, "sat6 kept", 32'h7);
        wr(IDX_SOFT_RST, 32'h0);
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; start = 1'b0; elem = 3'h0; kinds = '0;
        ce = 1'b1;
        n_mismatch = 0; checks = 0; cyc = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_config();
        t_count();
        t_irq();
        t_freeze();
        t_bad_addr();
        wrap_up();
    end
endmodule
`default_nettype wire
